// ==== rtl/dosm_top.sv ====
// Operating-state sequencer for a servo drive, with error response control.
// Assumes fieldbus command pulses and monitor levels are on core_clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module dosm_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Configuration
   input wire logic fieldbus_mode,
   input wire logic specific_fieldbus,
   input wire logic [7:0] legacy_compat_setting,
   input wire logic halt_req,
   // Fieldbus commands from drive_control_word_param
   input wire dosm_pkg::dosm_cmd_t drive_control_word_param,
   // Monitoring
   input wire dosm_pkg::dosm_mon_t mon,
   input wire logic [15:0] actual_speed_rpm,
   input wire logic [2:0] error_class,
   // Pins, asynchronous
   input wire logic enable_pin,
   input wire logic fault_reset_pin,
   input wire logic power_removal_input_a,
   input wire logic power_removal_input_b,
   // State and drive controls
   output dosm_pkg::dosm_state_t state,
   output dosm_pkg::dosm_drive_t drive
);
   dosm_pkg::dosm_state_t state_reg;
   dosm_pkg::dosm_state_t state_next;
   dosm_pkg::dosm_drive_t drive_reg;
   dosm_pkg::dosm_drive_t drive_next;
   logic qs_class1_reg;
   logic qs_class1_next;
   logic severe_reg;
   logic severe_next;
   logic enable_lvl;
   logic enable_rise;
   logic fr_rise;
   logic pwra_lvl;
   logic pwrb_lvl;

   dosm_insync u_sync_enable (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(enable_pin),
      .level_out(enable_lvl),
      .rise_out(enable_rise)
   );
   dosm_insync u_sync_fault_reset (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(fault_reset_pin),
      .level_out(),
      .rise_out(fr_rise)
   );
   dosm_insync u_sync_pwra (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(power_removal_input_a),
      .level_out(pwra_lvl),
      .rise_out()
   );
   dosm_insync u_sync_pwrb (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(power_removal_input_b),
      .level_out(pwrb_lvl),
      .rise_out()
   );

   // Fieldbus commands are masked outside fieldbus control mode.
   wire dosm_pkg::dosm_cmd_t cmd = fieldbus_mode ? drive_control_word_param : '0;
   // The enable pin only acts in local control mode; in fieldbus mode the bus owns the state.
   wire en_rise = enable_rise & ~fieldbus_mode;
   wire en_fall = ~enable_lvl & ~fieldbus_mode;
   wire fault_reset = cmd.fault_reset | fr_rise;
   wire power_ok = pwra_lvl & pwrb_lvl;
   wire power_removed = ~power_ok;
   wire speed_low = actual_speed_rpm < dosm_pkg::SPEED_LIMIT_RPM;
   wire err_class1 = error_class == dosm_pkg::ERR_CLASS1;
   wire err_class2 = error_class == dosm_pkg::ERR_CLASS2;
   wire err_severe = (error_class == dosm_pkg::ERR_CLASS3) | (error_class == dosm_pkg::ERR_CLASS4);
   // Power removal only counts as an error once the stage could carry current.
   wire pr_event = power_removed & (state_reg == dosm_pkg::ST_SWITCHED_ON | state_reg == dosm_pkg::ST_OP_ENABLED |
                   state_reg == dosm_pkg::ST_QUICK_STOP);
   wire err_t13 = err_class2 | err_severe | pr_event;
   wire shutdown_needed = fieldbus_mode & specific_fieldbus &
                          (legacy_compat_setting == dosm_pkg::COMPAT_SHUTDOWN_REQ);
   wire t2_ok = mon.encoder_ok & mon.dc_bus_ok & power_ok & speed_low &
                (~shutdown_needed | cmd.shutdown);
   wire in_fault_states = state_reg == dosm_pkg::ST_FAULT_REACTION | state_reg == dosm_pkg::ST_FAULT;

   always_comb begin
      state_next = state_reg;
      qs_class1_next = qs_class1_reg;
      severe_next = severe_reg;
      if (err_t13 & ~in_fault_states) begin
         state_next = dosm_pkg::ST_FAULT_REACTION;
         severe_next = err_severe | pr_event;
         qs_class1_next = 1'b0;
      end else begin
         unique case (state_reg)
            dosm_pkg::ST_START: begin
               if (mon.init_ok & speed_low) state_next = dosm_pkg::ST_NOT_READY;
            end
            dosm_pkg::ST_NOT_READY: begin
               if (mon.commissioned) state_next = dosm_pkg::ST_SWITCH_ON_DISABLED;
            end
            dosm_pkg::ST_SWITCH_ON_DISABLED: begin
               if (t2_ok) state_next = dosm_pkg::ST_READY;
            end
            dosm_pkg::ST_READY: begin
               if (~mon.dc_bus_ok | cmd.disable_voltage) state_next = dosm_pkg::ST_SWITCH_ON_DISABLED;
               else if (cmd.switch_on | en_rise) state_next = dosm_pkg::ST_SWITCHED_ON;
            end
            dosm_pkg::ST_SWITCHED_ON: begin
               if (cmd.disable_voltage) state_next = dosm_pkg::ST_SWITCH_ON_DISABLED;
               else if (cmd.shutdown | (en_fall & ~en_rise)) state_next = dosm_pkg::ST_READY;
               // Phase, earth and parameter checks must pass before the stage is energised.
               else if ((cmd.enable_op | ~fieldbus_mode) & mon.checks_ok) state_next = dosm_pkg::ST_OP_ENABLED;
            end
            dosm_pkg::ST_OP_ENABLED: begin
               if (err_class1 | cmd.quick_stop) begin
                  state_next = dosm_pkg::ST_QUICK_STOP;
                  qs_class1_next = err_class1;
               end else if (cmd.disable_voltage) state_next = dosm_pkg::ST_SWITCH_ON_DISABLED;
               else if (cmd.shutdown) state_next = dosm_pkg::ST_READY;
               else if (cmd.disable_op | en_fall) state_next = dosm_pkg::ST_SWITCHED_ON;
            end
            dosm_pkg::ST_QUICK_STOP: begin
               if (cmd.disable_voltage) state_next = dosm_pkg::ST_SWITCH_ON_DISABLED;
               else if ((qs_class1_reg & fault_reset & ~mon.error_cause_present) | (~qs_class1_reg & cmd.enable_op))
                  state_next = dosm_pkg::ST_OP_ENABLED;
            end
            dosm_pkg::ST_FAULT_REACTION: begin
               // Severe errors skip the ramp; class 2 waits for the quick stop to finish.
               if (severe_reg | mon.quick_stop_done) state_next = dosm_pkg::ST_FAULT;
            end
            dosm_pkg::ST_FAULT: begin
               if (fault_reset & ~mon.error_cause_present) state_next = dosm_pkg::ST_SWITCH_ON_DISABLED;
            end
            default: state_next = dosm_pkg::ST_FAULT;
         endcase
      end
   end

   // Drive controls follow the next state so they switch together with it.
   wire st6 = state_next == dosm_pkg::ST_OP_ENABLED;
   wire st7 = state_next == dosm_pkg::ST_QUICK_STOP;
   wire st8 = state_next == dosm_pkg::ST_FAULT_REACTION;
   wire ramping = st7 | (st8 & ~severe_next);
   always_comb begin
      drive_next = '0;
      drive_next.amp_on = st6 | ramping;
      drive_next.brake_released = st6 | ramping;
      drive_next.mode_run = st6 & ~halt_req;
      drive_next.halt = st6 & halt_req;
      drive_next.quick_stop = ramping;
      drive_next.abort_travel = ~st6;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= dosm_pkg::dosm_state_t'(dosm_pkg::STATE_RESET);
         drive_reg <= '0;
         qs_class1_reg <= 1'b0;
         severe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         drive_reg <= drive_next;
         qs_class1_reg <= qs_class1_next;
         severe_reg <= severe_next;
      end
   end
   assign state = state_reg;
   assign drive = drive_reg;

   property p_t13;
      @(posedge core_clk) disable iff (srst) (err_class2 & ~in_fault_states) |=> state_reg == dosm_pkg::ST_FAULT_REACTION;
   endproperty
   a_t13: assert property (p_t13) else $error("class 2 error did not enter fault reaction");
   property p_severe_off;
      @(posedge core_clk) disable iff (srst) (err_severe & ~in_fault_states) |=> ~drive_reg.amp_on ##1 state_reg == dosm_pkg::ST_FAULT;
   endproperty
   a_severe_off: assert property (p_severe_off) else $error("severe error did not cut amplifier");
   sequence s_c2_ramp;
      state_reg == dosm_pkg::ST_FAULT_REACTION && !severe_reg && drive_reg.quick_stop;
   endsequence
   property p_class2;
      @(posedge core_clk) disable iff (srst) s_c2_ramp ##0 mon.quick_stop_done |=> state_reg == dosm_pkg::ST_FAULT && !drive_reg.amp_on;
   endproperty
   a_class2: assert property (p_class2) else $error("class 2 response did not end in fault");
   property p_fault_hold;
      @(posedge core_clk) disable iff (srst) (state_reg == dosm_pkg::ST_FAULT && mon.error_cause_present && !err_t13) |=> state_reg == dosm_pkg::ST_FAULT;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left while cause present");
   property p_sw_on;
      @(posedge core_clk) disable iff (srst) state_reg == dosm_pkg::ST_SWITCHED_ON |-> !drive_reg.amp_on && !drive_reg.mode_run;
   endproperty
   a_sw_on: assert property (p_sw_on) else $error("motor powered in switched on");
   property p_halt;
      @(posedge core_clk) disable iff (srst) (state_reg == dosm_pkg::ST_OP_ENABLED && drive_reg.halt) |-> drive_reg.amp_on && !drive_reg.mode_run;
   endproperty
   a_halt: assert property (p_halt) else $error("halt lost amplifier");
   property p_bus_gate;
      @(posedge core_clk) disable iff (srst) (!fieldbus_mode && state_reg == dosm_pkg::ST_READY && !en_rise && mon.dc_bus_ok) |=> state_reg != dosm_pkg::ST_SWITCHED_ON;
   endproperty
   a_bus_gate: assert property (p_bus_gate) else $error("command taken outside fieldbus mode");
   property p_t2;
      @(posedge core_clk) disable iff (srst) (state_reg == dosm_pkg::ST_SWITCH_ON_DISABLED && !speed_low) |=> state_reg != dosm_pkg::ST_READY;
   endproperty
   a_t2: assert property (p_t2) else $error("T2 taken with speed too high");
   property p_t2_gate;
      @(posedge core_clk) disable iff (srst)
         (state_reg == dosm_pkg::ST_SWITCH_ON_DISABLED && shutdown_needed && !cmd.shutdown) |=>
         state_reg != dosm_pkg::ST_READY;
   endproperty
   a_t2_gate: assert property (p_t2_gate) else $error("T2 taken without shutdown command");
   property p_t4_checks;
      @(posedge core_clk) disable iff (srst)
         (state_reg == dosm_pkg::ST_SWITCHED_ON && !mon.checks_ok && !err_t13) |=>
         state_reg != dosm_pkg::ST_OP_ENABLED;
   endproperty
   a_t4_checks: assert property (p_t4_checks) else $error("T4 taken with checks failing");
   property p_t4;
      @(posedge core_clk) disable iff (srst) (state_reg == dosm_pkg::ST_SWITCHED_ON) ##1 (state_reg == dosm_pkg::ST_OP_ENABLED) |-> drive_reg.amp_on && drive_reg.brake_released;
   endproperty
   a_t4: assert property (p_t4) else $error("T4 did not energise and release");
endmodule // dosm_top
`default_nettype wire

// ==== rtl/dosm_pkg.sv ====
// Package for the drive operating-state sequencer: state codes, error classes, port bundles.
// Assumes a single 50 MHz clock domain; no bus, all controls are plain ports.
package dosm_pkg;
   // Operating states, numbered as displayed.
   typedef enum logic [3:0] {
      ST_START = 4'h1,
      ST_NOT_READY = 4'h2,
      ST_SWITCH_ON_DISABLED = 4'h3,
      ST_READY = 4'h4,
      ST_SWITCHED_ON = 4'h5,
      ST_OP_ENABLED = 4'h6,
      ST_QUICK_STOP = 4'h7,
      ST_FAULT_REACTION = 4'h8,
      ST_FAULT = 4'h9
   } dosm_state_t;
   // Error class codes on the error event port; zero means no error.
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_CLASS1 = 3'h1;
   localparam logic [2:0] ERR_CLASS2 = 3'h2;
   localparam logic [2:0] ERR_CLASS3 = 3'h3;
   localparam logic [2:0] ERR_CLASS4 = 3'h4;
   // Speed limit for T2 in rpm.
   localparam logic [15:0] SPEED_LIMIT_RPM = 16'h03E8;
   // Legacy compatibility value that makes shutdown a T2 condition.
   localparam logic [7:0] COMPAT_SHUTDOWN_REQ = 8'h01;
   // Reset value of the sequencer state.
   localparam logic [3:0] STATE_RESET = 4'h1;
   // Fieldbus command strobes, one-cycle pulses.
   typedef struct packed {
      logic shutdown;
      logic switch_on;
      logic enable_op;
      logic disable_op;
      logic disable_voltage;
      logic quick_stop;
      logic fault_reset;
   } dosm_cmd_t;
   // Monitoring status levels.
   typedef struct packed {
      logic init_ok;
      logic commissioned;
      logic encoder_ok;
      logic dc_bus_ok;
      logic checks_ok;
      logic error_cause_present;
      logic quick_stop_done;
   } dosm_mon_t;
   // Power stage and motion controls driven out.
   typedef struct packed {
      logic amp_on;
      logic brake_released;
      logic mode_run;
      logic halt;
      logic quick_stop;
      logic abort_travel;
   } dosm_drive_t;
endpackage

// ==== rtl/dosm_insync.sv ====
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module dosm_insync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Pin side
   input wire logic pin_in,
   // Core side
   output logic level_out,
   output logic rise_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   wire agree = (s2_reg == s3_reg);
   wire level_next = agree ? s2_reg : level_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
      end
   end
   assign level_out = level_reg;
   assign rise_out = level_next & ~level_reg;
endmodule // dosm_insync
`default_nettype wire

// ==== sim/dosm_host_model.sv ====
// Host-side model: fieldbus command pulses and the discrete control pins of the sequencer.
// Assumes a free-running core_clk; every change lands on a falling edge.
`timescale 1ns/1ns
`default_nettype none
module dosm_host_model (
   // Clock
   input wire logic core_clk,
   // Fieldbus command word and pins
   output dosm_pkg::dosm_cmd_t cmd,
   output logic enable_pin,
   output logic fault_reset_pin,
   output logic pwr_a,
   output logic pwr_b
);
   initial begin
      cmd = '0;
      enable_pin = 1'b0;
      fault_reset_pin = 1'b0;
      pwr_a = 1'b0;
      pwr_b = 1'b0;
   end
   // A command is a single-cycle pulse, so no word is ever seen on two edges.
   task automatic send(input dosm_pkg::dosm_cmd_t c);
      @(negedge core_clk);
      cmd = c;
      @(negedge core_clk);
      cmd = '0;
   endtask
   // The pulse is held long enough to pass the pin filter of the device.
   task automatic fault_reset();
      @(negedge core_clk);
      fault_reset_pin = 1'b1;
      repeat (6) @(negedge core_clk);
      fault_reset_pin = 1'b0;
   endtask
   task automatic set_enable(input logic v);
      @(negedge core_clk);
      enable_pin = v;
   endtask
   task automatic set_power(input logic v);
      @(negedge core_clk);
      pwr_a = v;
      pwr_b = v;
   endtask
endmodule // dosm_host_model
`default_nettype wire

// ==== sim/dosm_top_tb.sv ====
// Self-checking bench for the operating-state sequencer.
// Assumes the host model supplies commands and pins; monitors are driven here.
`timescale 1ns/1ns
`default_nettype none
module dosm_top_tb;
   logic core_clk;
   logic srst;
   logic fieldbus_mode;
   logic specific_fieldbus;
   logic [7:0] legacy_compat_setting;
   logic halt_req;
   dosm_pkg::dosm_mon_t mon;
   logic [15:0] speed;
   logic [2:0] err;
   dosm_pkg::dosm_cmd_t cmd;
   logic en;
   logic fr;
   logic pa;
   logic pb;
   dosm_pkg::dosm_state_t state;
   dosm_pkg::dosm_drive_t drive;
   int fail_count = 0;
   int samples_checked = 0;
   // Rows start in state 4 with the legacy shutdown gate on, so T2 waits for a command.
   dosm_pkg::dosm_cmd_t row_cmd [13] = '{7'h20, 7'h10, 7'h08, 7'h10, 7'h02, 7'h10, 7'h04,
      7'h00, 7'h40, 7'h20, 7'h40, 7'h04, 7'h40};
   logic [3:0] row_state [13] = '{4'h5, 4'h6, 4'h5, 4'h6, 4'h7, 4'h6, 4'h3, 4'h3, 4'h4, 4'h5,
      4'h4, 4'h3, 4'h4};
   dosm_host_model host (.core_clk(core_clk), .cmd(cmd), .enable_pin(en), .fault_reset_pin(fr),
      .pwr_a(pa), .pwr_b(pb));
   dosm_top uut (.core_clk(core_clk), .srst(srst), .fieldbus_mode(fieldbus_mode),
      .specific_fieldbus(specific_fieldbus), .legacy_compat_setting(legacy_compat_setting),
      .halt_req(halt_req), .drive_control_word_param(cmd), .mon(mon), .actual_speed_rpm(speed),
      .error_class(err), .enable_pin(en), .fault_reset_pin(fr), .power_removal_input_a(pa),
      .power_removal_input_b(pb), .state(state), .drive(drive));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check_state(input logic [3:0] exp);
      samples_checked++;
      if (state !== exp) begin
         fail_count++;
         $display("Error at %0t: state %0h, expected %0h", $time, state, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: drive bit %b, expected %b", $time, got, exp);
      end
   endtask
   // Pins pass a filter, so the wait is bounded rather than a fixed count.
   task automatic wait_state(input logic [3:0] exp);
      int n;
      n = 0;
      while (state !== exp && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 40) begin
         fail_count++;
         $display("Error at %0t: timed out waiting for state %0h", $time, exp);
         tally_and_finish();
      end else begin
         check_state(exp);
      end
   endtask
   initial begin
      srst = 1'b1;
      fieldbus_mode = 1'b0;
      specific_fieldbus = 1'b0;
      legacy_compat_setting = 8'h00;
      halt_req = 1'b0;
      mon = '0;
      speed = 16'h0000;
      err = 3'h0;
      repeat (10) @(negedge core_clk);
      check_state(4'h1);
      check_bit(drive.amp_on, 1'b0);
      check_bit(drive.abort_travel, 1'b0);
      speed = 16'hFFFF;
      srst = 1'b0;
      $display("Reset test done");
      mon.init_ok = 1'b1;
      repeat (4) @(negedge core_clk);
      check_state(4'h1);
      check_bit(drive.abort_travel, 1'b1);
      speed = 16'h0000;
      wait_state(4'h2);
      mon.commissioned = 1'b1;
      wait_state(4'h3);
      mon.encoder_ok = 1'b1;
      mon.dc_bus_ok = 1'b1;
      mon.checks_ok = 1'b1;
      speed = 16'h03E8;
      host.set_power(1'b1);
      repeat (8) @(negedge core_clk);
      check_state(4'h3);
      speed = 16'h03E7;
      wait_state(4'h4);
      $display("Start-up test done");
      host.set_enable(1'b1);
      wait_state(4'h6);
      check_bit(drive.amp_on, 1'b1);
      check_bit(drive.brake_released, 1'b1);
      halt_req = 1'b1;
      repeat (2) @(negedge core_clk);
      check_bit(drive.halt, 1'b1);
      check_bit(drive.mode_run, 1'b0);
      check_bit(drive.amp_on, 1'b1);
      halt_req = 1'b0;
      host.set_enable(1'b0);
      wait_state(4'h4);
      check_bit(drive.brake_released, 1'b0);
      $display("Local enable test done");
      host.set_enable(1'b1);
      wait_state(4'h6);
      err = 3'h2;
      mon.error_cause_present = 1'b1;
      wait_state(4'h8);
      check_bit(drive.quick_stop, 1'b1);
      check_bit(drive.abort_travel, 1'b1);
      repeat (4) @(negedge core_clk);
      check_state(4'h8);
      mon.quick_stop_done = 1'b1;
      wait_state(4'h9);
      check_bit(drive.amp_on, 1'b0);
      check_bit(drive.brake_released, 1'b0);
      err = 3'h0;
      mon.quick_stop_done = 1'b0;
      host.set_enable(1'b0);
      host.fault_reset();
      repeat (6) @(negedge core_clk);
      check_state(4'h9);
      mon.error_cause_present = 1'b0;
      host.fault_reset();
      wait_state(4'h4);
      $display("Class 2 test done");
      for (int i = 0; i < 3; i++) begin
         host.set_enable(1'b1);
         wait_state(4'h6);
         if (i < 2) begin
            err = 3'h3 + 3'(i);
         end else begin
            host.set_power(1'b0);
         end
         wait_state(4'h8);
         check_bit(drive.amp_on, 1'b0);
         wait_state(4'h9);
         err = 3'h0;
         host.set_power(1'b1);
         host.set_enable(1'b0);
         host.fault_reset();
         wait_state(4'h4);
      end
      $display("Immediate off test done");
      host.send(7'h20);
      repeat (6) @(negedge core_clk);
      check_state(4'h4);
      fieldbus_mode = 1'b1;
      specific_fieldbus = 1'b1;
      legacy_compat_setting = 8'h01;
      host.set_enable(1'b1);
      repeat (8) @(negedge core_clk);
      check_state(4'h4);
      for (int r = 0; r < 13; r++) begin
         host.send(row_cmd[r]);
         wait_state(row_state[r]);
         repeat (4) @(negedge core_clk);
         check_state(row_state[r]);
         if (row_state[r] != 4'h7) begin
            check_bit(drive.amp_on, row_state[r] == 4'h6);
            check_bit(drive.mode_run, row_state[r] == 4'h6);
         end
      end
      $display("Fieldbus row test done");
      host.send(7'h04);
      wait_state(4'h3);
      repeat (4) @(negedge core_clk);
      check_state(4'h3);
      specific_fieldbus = 1'b0;
      wait_state(4'h4);
      specific_fieldbus = 1'b1;
      host.send(7'h04);
      wait_state(4'h3);
      legacy_compat_setting = 8'hFE;
      wait_state(4'h4);
      legacy_compat_setting = 8'h01;
      mon.checks_ok = 1'b0;
      host.send(7'h20);
      wait_state(4'h5);
      host.send(7'h10);
      repeat (4) @(negedge core_clk);
      check_state(4'h5);
      mon.checks_ok = 1'b1;
      host.send(7'h10);
      wait_state(4'h6);
      $display("Shutdown gate test done");
      err = 3'h1;
      wait_state(4'h7);
      err = 3'h0;
      host.send(7'h01);
      wait_state(4'h6);
      $display("Class 1 test done");
      // A reset in mid-run must drop the energised stage at once.
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      check_state(4'h1);
      check_bit(drive.amp_on, 1'b0);
      check_bit(drive.brake_released, 1'b0);
      srst = 1'b0;
      wait_state(4'h3);
      check_bit(drive.abort_travel, 1'b1);
      repeat (6) @(negedge core_clk);
      check_state(4'h3);
      $display("Mid-run reset test done");
      tally_and_finish();
   end
endmodule // dosm_top_tb
`default_nettype wire
